// ===== core/rcmio_top.sv
// reference clock generation, loss pins, straps and gpio with an
// avalon-mm register slave
// assumes sys_clk is the buffered oscillator input clock
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "rcmio_defines.svh"
module rcmio_top #(
  parameter int unsigned BOOT_CYCLES = 32'(`RCMIO_BOOT_CYC) // startup wait
) (
  input  wire logic                sys_clk,            // oscillator clock
  input  wire logic                rst_n,              // async reset, low
  input  wire logic [9:0]          avs_address,        // byte address
  input  wire logic                avs_read,           // read request
  input  wire logic                avs_write,          // write request
  input  wire rcmio_pkg::rcmio_word_t avs_writedata,   // write data
  input  wire logic [3:0]          avs_byteenable,     // byte lanes
  output rcmio_pkg::rcmio_word_t   avs_readdata,       // read data
  output logic                     avs_waitrequest,    // stall
  output logic                     irq,                // level interrupt
  input  wire rcmio_pkg::rcmio_chan_t chan_loss,       // raw loss per chan
  input  wire rcmio_pkg::rcmio_chan_t rcv_clk,         // recovered clocks
  input  wire rcmio_pkg::rcmio_strap_t freq_select_strap, // osc straps
  output rcmio_pkg::rcmio_chan_t   loss_indicator_n,   // loss pins, high
  output logic                     crystal_output,     // inverted osc
  output logic                     gen_t1_rate_output, // 1.544 MHz
  output logic                     gen_e1_rate_output, // 2.048 MHz
  output logic                     ref_output_a,       // reference a
  output logic                     ref_output_b,       // reference b
  input  wire logic [1:0]          gpio_in,            // gpio pin level
  output logic [1:0]               gpio_out,           // gpio drive value
  output logic [1:0]               gpio_oe             // gpio drive enable
);
  import rcmio_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  rcmio_chan_t  loss_meta_reg;
  rcmio_chan_t  loss_sync_reg;
  rcmio_chan_t  rcv_meta_reg;
  rcmio_chan_t  rcv_sync_reg;
  rcmio_strap_t strap_meta_reg;
  rcmio_strap_t strap_sync_reg;
  rcmio_strap_t strap_reg;
  logic [1:0]   gpio_meta_reg;
  logic [1:0]   gpio_sync_reg;
  rcmio_chan_t  loss_pin_reg;

  logic [31:0]  boot_cnt_reg;
  logic         boot_done;

  logic [31:0]  nco_t1_reg;
  logic [31:0]  nco_e1_reg;
  logic         mclk;

  logic [7:0]   gpio_ctl_reg;
  logic [7:0]   refsel_reg;
  logic [7:0]   refctl_reg;
  rcmio_chan_t  irq_stat_reg;
  rcmio_chan_t  irq_en_reg;
  rcmio_chan_t  loss_rise;

  rcmio_bus_e   bus_reg;
  rcmio_word_t  rdata_reg;
  rcmio_word_t  rdata_next;
  logic         req;
  logic         wr_go;
  logic [7:0]   idx;
  logic [7:0]   wbyte;
  logic [13:0]  osc_khz;
  logic [1:0]   gpio_level;

  rcmio_ref_if  ref_a_if ();
  rcmio_ref_if  ref_b_if ();

  // ----------------------------------------------------------------
  // synchronisers for pins
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      loss_meta_reg  <= '0;
      loss_sync_reg  <= '0;
      rcv_meta_reg   <= '0;
      rcv_sync_reg   <= '0;
      strap_meta_reg <= '0;
      strap_sync_reg <= '0;
      gpio_meta_reg  <= '0;
      gpio_sync_reg  <= '0;
    end
    else
    begin
      loss_meta_reg  <= chan_loss;
      loss_sync_reg  <= loss_meta_reg;
      rcv_meta_reg   <= rcv_clk;
      rcv_sync_reg   <= rcv_meta_reg;
      strap_meta_reg <= freq_select_strap;
      strap_sync_reg <= strap_meta_reg;
      gpio_meta_reg  <= gpio_in;
      gpio_sync_reg  <= gpio_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // loss pins
  // ----------------------------------------------------------------
  // follow channel loss
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      loss_pin_reg <= '0;
    end
    else
    begin
      loss_pin_reg <= loss_sync_reg;
    end
  end

  assign loss_indicator_n = loss_pin_reg;
  assign loss_rise        = loss_sync_reg & ~loss_pin_reg;

  // ----------------------------------------------------------------
  // startup wait and strap capture
  // ----------------------------------------------------------------
  // hold off register access
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      boot_cnt_reg <= '0;
    end
    else if (!boot_done)
    begin
      boot_cnt_reg <= boot_cnt_reg + 32'd1;
    end
  end

  assign boot_done = (boot_cnt_reg >= BOOT_CYCLES);

  // straps settle during startup and freeze after it
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_reg <= '0;
    end
    else if (!boot_done)
    begin
      strap_reg <= strap_sync_reg;
    end
  end

  always_comb
  begin
    osc_khz = strap_reg[2] ? `RCMIO_E1_KHZ : `RCMIO_T1_KHZ;
    osc_khz = 14'(osc_khz * ({12'd0, strap_reg[1:0]} + 14'd1));
  end

  // ----------------------------------------------------------------
  // clock generator
  // ----------------------------------------------------------------
  // phase accumulators
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      nco_t1_reg <= '0;
      nco_e1_reg <= '0;
    end
    else
    begin
      nco_t1_reg <= nco_t1_reg + 32'(`RCMIO_NCO_T1);
      nco_e1_reg <= nco_e1_reg + 32'(`RCMIO_NCO_E1);
    end
  end

  assign gen_t1_rate_output = nco_t1_reg[31];
  assign gen_e1_rate_output = nco_e1_reg[31];

  assign mclk = refctl_reg[`RCMIO_REFERENCE_OUTPUT_CONTROL_E1] ? nco_e1_reg[31] : nco_t1_reg[31];

  assign crystal_output = ~sys_clk;

  // ----------------------------------------------------------------
  // reference outputs
  // ----------------------------------------------------------------
  // output a and b selection
  assign ref_a_if.rcv_clk   = rcv_sync_reg;
  assign ref_a_if.loss      = loss_sync_reg;
  assign ref_a_if.mclk      = mclk;
  assign ref_a_if.sel       = refsel_reg[`RCMIO_REF_A_LSB +: 3];
  assign ref_a_if.hold_high = refctl_reg[`RCMIO_REFERENCE_OUTPUT_CONTROL_HOLD];

  assign ref_b_if.rcv_clk   = rcv_sync_reg;
  assign ref_b_if.loss      = loss_sync_reg;
  assign ref_b_if.mclk      = mclk;
  assign ref_b_if.sel       = refsel_reg[`RCMIO_REF_B_LSB +: 3];
  assign ref_b_if.hold_high = refctl_reg[`RCMIO_REFERENCE_OUTPUT_CONTROL_HOLD];

  rcmio_ref_mux u_ref_a (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .ref_if  (ref_a_if.mux)
  );

  rcmio_ref_mux u_ref_b (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .ref_if  (ref_b_if.mux)
  );

  assign ref_output_a = ref_a_if.ref_out;
  assign ref_output_b = ref_b_if.ref_out;

  // ----------------------------------------------------------------
  // general purpose pins
  // ----------------------------------------------------------------
  // direction and drive
  assign gpio_oe  = gpio_ctl_reg[`RCMIO_GPIO_DIR_LSB +: 2];
  assign gpio_out = gpio_ctl_reg[`RCMIO_GPIO_LVL_LSB +: 2];

  assign gpio_level = (gpio_oe & gpio_out) | (~gpio_oe & gpio_sync_reg);

  // ----------------------------------------------------------------
  // avalon slave
  // ----------------------------------------------------------------
  assign req             = avs_read | avs_write;
  assign idx             = avs_address[9:2];
  assign wbyte           = avs_writedata[7:0];
  assign wr_go           = avs_write & avs_byteenable[0] &
                           (bus_reg == RCMIO_BUS_ANSWER);
  assign avs_waitrequest = req & (bus_reg != RCMIO_BUS_ANSWER);
  assign avs_readdata    = rdata_reg;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_reg <= RCMIO_BUS_IDLE;
    end
    else
    begin
      unique case (bus_reg)
        RCMIO_BUS_IDLE:
        begin
          if (req && boot_done)
          begin
            bus_reg <= RCMIO_BUS_ANSWER;
          end
        end
        RCMIO_BUS_ANSWER:
        begin
          bus_reg <= RCMIO_BUS_IDLE;
        end
      endcase
    end
  end

  always_comb
  begin
    rdata_next = '0;
    unique case (idx)
      `RCMIO_IDX_GPIO:
      begin
        rdata_next[7:0] = gpio_ctl_reg;
        rdata_next[`RCMIO_GPIO_LVL_LSB +: 2] = gpio_level;
      end
      `RCMIO_IDX_REFSEL:   rdata_next[7:0] = refsel_reg;
      `RCMIO_IDX_REFCTL:   rdata_next[7:0] = refctl_reg;
      `RCMIO_IDX_IRQ_STAT: rdata_next[7:0] = irq_stat_reg;
      `RCMIO_IDX_IRQ_EN:   rdata_next[7:0] = irq_en_reg;
      `RCMIO_IDX_STRAP:
      begin
        rdata_next[2:0]   = strap_reg;
        rdata_next[13:3]  = '0;
        rdata_next[31:16] = {8'h00, loss_pin_reg};
        rdata_next[15:0]  = {osc_khz[12:0], strap_reg};
      end
      default:             rdata_next = '0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_reg <= '0;
    end
    else if (avs_read && bus_reg == RCMIO_BUS_IDLE && boot_done)
    begin
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // gpio register write
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gpio_ctl_reg <= `RCMIO_RST_GPIO;
    end
    else if (wr_go && idx == `RCMIO_IDX_GPIO)
    begin
      gpio_ctl_reg <= {4'h0, wbyte[3:0]};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      refsel_reg <= `RCMIO_RST_REFSEL;
    end
    else if (wr_go && idx == `RCMIO_IDX_REFSEL)
    begin
      refsel_reg <= wbyte & 8'h77;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      refctl_reg <= `RCMIO_RST_REFCTL;
    end
    else if (wr_go && idx == `RCMIO_IDX_REFCTL)
    begin
      refctl_reg <= wbyte & 8'h03;
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_en_reg <= `RCMIO_RST_IRQ_EN;
    end
    else if (wr_go && idx == `RCMIO_IDX_IRQ_EN)
    begin
      irq_en_reg <= wbyte;
    end
  end

  // a new loss beats a clear in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_stat_reg <= '0;
    end
    else if (wr_go && idx == `RCMIO_IDX_IRQ_CLR)
    begin
      irq_stat_reg <= (irq_stat_reg & ~wbyte) | loss_rise;
    end
    else
    begin
      irq_stat_reg <= irq_stat_reg | loss_rise;
    end
  end

  assign irq = |(irq_stat_reg & irq_en_reg);
endmodule

// ===== core/rcmio_defines.svh
// register indices, field positions, reset values and timing
// included by the package and by every design file that decodes
`ifndef RCMIO_DEFINES_SVH
`define RCMIO_DEFINES_SVH

// register indices, byte address is four times the index
`define RCMIO_IDX_GPIO     8'h06
`define RCMIO_IDX_REFSEL   8'h07
`define RCMIO_IDX_REFCTL   8'h3e
`define RCMIO_IDX_IRQ_STAT 8'h40
`define RCMIO_IDX_IRQ_CLR  8'h41
`define RCMIO_IDX_IRQ_EN   8'h42
`define RCMIO_IDX_STRAP    8'h43

// field positions
`define RCMIO_GPIO_DIR_LSB 0
`define RCMIO_GPIO_LVL_LSB 2
`define RCMIO_REF_A_LSB    0
`define RCMIO_REF_B_LSB    4
`define RCMIO_REFERENCE_OUTPUT_CONTROL_HOLD    0
`define RCMIO_REFERENCE_OUTPUT_CONTROL_E1      1
`define RCMIO_STRAP_LOSS   16

// reset values
`define RCMIO_RST_GPIO     8'h00
`define RCMIO_RST_REFSEL   8'h00
`define RCMIO_RST_REFCTL   8'h00
`define RCMIO_RST_IRQ_EN   8'h00

// rates and times
`define RCMIO_CLK_HZ       64'd200000000
`define RCMIO_T1_HZ        64'd1544000
`define RCMIO_E1_HZ        64'd2048000
`define RCMIO_T1_KHZ       14'd1544
`define RCMIO_E1_KHZ       14'd2048
`define RCMIO_BOOT_MS      64'd2
`define RCMIO_BOOT_CYC     (`RCMIO_BOOT_MS * `RCMIO_CLK_HZ / 64'd1000)
`define RCMIO_NCO_T1       ((`RCMIO_T1_HZ << 32) / `RCMIO_CLK_HZ)
`define RCMIO_NCO_E1       ((`RCMIO_E1_HZ << 32) / `RCMIO_CLK_HZ)

`endif

// ===== core/rcmio_pkg.sv
// types shared by the reference clock and misc pin block
// assumes rcmio_defines.svh is on the include path
package rcmio_pkg;
  `include "rcmio_defines.svh"

  typedef logic [7:0]  rcmio_chan_t;
  typedef logic [2:0]  rcmio_sel_t;
  typedef logic [2:0]  rcmio_strap_t;
  typedef logic [31:0] rcmio_word_t;

  typedef enum logic {
    RCMIO_BUS_IDLE,
    RCMIO_BUS_ANSWER
  } rcmio_bus_e;
endpackage

// ===== core/rcmio_ref_if.sv
// one reference output path: selection, fallback control and result
// assumes the control side and the selector share one clock
`timescale 1ns/1ps
interface rcmio_ref_if;
  import rcmio_pkg::*;
  rcmio_chan_t rcv_clk;
  rcmio_chan_t loss;
  logic        mclk;
  rcmio_sel_t  sel;
  logic        hold_high;
  logic        ref_out;

  modport ctrl (output rcv_clk, loss, mclk, sel, hold_high, input ref_out);
  modport mux  (input rcv_clk, loss, mclk, sel, hold_high, output ref_out);
endinterface

// ===== core/rcmio_ref_mux.sv
// reference clock selector for one output
// assumes all inputs are already synchronous to sys_clk
`timescale 1ns/1ps
module rcmio_ref_mux (
  input  wire logic sys_clk, // system clock
  input  wire logic rst_n,   // async reset, active low
  rcmio_ref_if.mux  ref_if   // selection and result
);
  import rcmio_pkg::*;

  logic sel_loss;
  logic sel_rcv;

  assign sel_loss = ref_if.loss[ref_if.sel];
  assign sel_rcv  = ref_if.rcv_clk[ref_if.sel];

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ref_if.ref_out <= 1'b1;
    end
    else if (sel_loss)
    begin
      ref_if.ref_out <= ref_if.hold_high | ref_if.mclk;
    end
    else
    begin
      ref_if.ref_out <= sel_rcv;
    end
  end
endmodule

// ===== test/rcmio_top_properties.sv
// port-level checks for the reference clock block
// assumes one sys_clk domain, rst_n async active low
`timescale 1ns/1ps
module rcmio_top_checker #(
  parameter int unsigned BOOT_CYCLES = 20 // startup wait
) (
  input wire logic                   sys_clk,            // clock
  input wire logic                   rst_n,              // reset, low
  input wire logic                   avs_read,           // read request
  input wire logic                   avs_write,          // write request
  input wire logic                   avs_waitrequest,    // stall
  input wire rcmio_pkg::rcmio_chan_t chan_loss,          // raw loss
  input wire rcmio_pkg::rcmio_chan_t loss_indicator_n,   // loss pins
  input wire logic                   crystal_output,     // inverted osc
  input wire logic                   gen_t1_rate_output, // t1 rate
  input wire logic                   gen_e1_rate_output, // e1 rate
  input wire logic [1:0]             gpio_out,           // gpio value
  input wire logic [1:0]             gpio_oe             // gpio enable
);
  import rcmio_pkg::*;
  logic [31:0] since_reg;
  logic [7:0]  t1_run_reg;
  logic [7:0]  e1_run_reg;
  logic        t1_prev_reg;
  logic        e1_prev_reg;
  // ----------------------------------------
  // cycles since reset, phase lengths
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n) since_reg <= '0;
    else if (since_reg < BOOT_CYCLES + 300) since_reg <= since_reg + 1;
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n) {t1_prev_reg, t1_run_reg} <= '0;
    else {t1_prev_reg, t1_run_reg} <= {gen_t1_rate_output,
      (gen_t1_rate_output != t1_prev_reg) ? 8'h01 : t1_run_reg + 8'h01};
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n) {e1_prev_reg, e1_run_reg} <= '0;
    else {e1_prev_reg, e1_run_reg} <= {gen_e1_rate_output,
      (gen_e1_rate_output != e1_prev_reg) ? 8'h01 : e1_run_reg + 8'h01};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  loss_pin_a: assert property (
    since_reg >= 6 |-> loss_indicator_n == $past(chan_loss, 3)) else $error("loss pin lag");
  boot_wait_a: assert property (
    since_reg < BOOT_CYCLES && (avs_read || avs_write) |-> avs_waitrequest)
    else $error("answer during startup");
  one_wait_a: assert property (
    since_reg > BOOT_CYCLES + 2 && (avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("answer late");
  idle_bus_a: assert property (
    !(avs_read || avs_write) |-> !avs_waitrequest) else $error("stall while idle");
  xtal_inv_a: assert property (crystal_output) else $error("crystal not inverted");
  t1_phase_a: assert property (
    since_reg > 200 && gen_t1_rate_output != t1_prev_reg |-> t1_run_reg inside {[64:65]})
    else $error("t1 phase length");
  e1_phase_a: assert property (
    since_reg > 200 && gen_e1_rate_output != e1_prev_reg |-> e1_run_reg inside {[48:49]})
    else $error("e1 phase length");
  gen_alive_a: assert property (
    t1_run_reg < 8'd66 && e1_run_reg < 8'd50) else $error("rate output stuck");
  gpio_hold_a: assert property (
    gpio_out != $past(gpio_out) || gpio_oe != $past(gpio_oe)
    |-> $past(avs_write && !avs_waitrequest)) else $error("gpio moved without write");
endmodule
bind rcmio_top rcmio_top_checker #(.BOOT_CYCLES(BOOT_CYCLES)) u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .chan_loss(chan_loss),
  .loss_indicator_n(loss_indicator_n), .crystal_output(crystal_output),
  .gen_t1_rate_output(gen_t1_rate_output), .gen_e1_rate_output(gen_e1_rate_output),
  .gpio_out(gpio_out), .gpio_oe(gpio_oe));

// ===== test/rcmio_far_end.sv
// far side: recovered line clocks and the gpio pins with pull-ups
// assumes sys_clk runs from time zero
`timescale 1ns/1ps
module rcmio_far_end (
  input  wire logic             sys_clk,  // system clock
  input  wire logic [1:0]       gpio_out, // device drive value
  input  wire logic [1:0]       gpio_oe,  // device drive enable
  input  wire logic [1:0]       ext_en,   // far side drives pin
  input  wire logic [1:0]       ext_val,  // far side pin value
  output logic [1:0]            gpio_pin, // resolved pin level
  output rcmio_pkg::rcmio_chan_t rcv_clk  // recovered clocks
);
  import rcmio_pkg::*;
  int unsigned tick = 0;
  // each link runs at its own rate
  always @(posedge sys_clk)
  begin
    tick <= tick + 1;
    for (int i = 0; i < 8; i++)
      rcv_clk[i] <= 1'((tick / (i + 2)) % 2);
  end
  // undriven pins float high on the pull-up
  assign gpio_pin = (gpio_oe & gpio_out) | (~gpio_oe & ext_en & ext_val) | (~gpio_oe & ~ext_en);
endmodule

// ===== test/rcmio_tb_top.sv
// self-checking bench for the reference clock block
// assumes a 200 MHz sys_clk and a short startup wait
`timescale 1ns/1ps
module rcmio_tb_top;
  import rcmio_pkg::*;
  localparam int unsigned BOOT = 20;
  logic         sys_clk = 1'b0;
  logic         rst_n = 1'b0;
  logic [9:0]   avs_address = 10'h000;
  logic         avs_read = 1'b0;
  logic         avs_write = 1'b0;
  rcmio_word_t  avs_writedata = 32'h0;
  logic [3:0]   avs_byteenable = 4'hf;
  rcmio_word_t  avs_readdata;
  logic         avs_waitrequest, irq, xtal, gen_t1, gen_e1, ref_a, ref_b;
  rcmio_chan_t  chan_loss = 8'h00;
  rcmio_chan_t  loss_pins, rcv_clk;
  rcmio_strap_t strap = 3'h0;
  logic [1:0]   gpio_pin, gpio_out, gpio_oe;
  logic [1:0]   ext_en = 2'h0;
  logic [1:0]   ext_val = 2'h0;
  int           mismatches = 0, checks_done = 0, cycles = 0, waits = 0;
  initial forever #2.5 sys_clk = ~sys_clk;
  rcmio_top #(.BOOT_CYCLES(BOOT)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .chan_loss(chan_loss),
    .rcv_clk(rcv_clk), .freq_select_strap(strap), .loss_indicator_n(loss_pins),
    .crystal_output(xtal), .gen_t1_rate_output(gen_t1), .gen_e1_rate_output(gen_e1),
    .ref_output_a(ref_a), .ref_output_b(ref_b), .gpio_in(gpio_pin),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe));
  rcmio_far_end u_far (.sys_clk(sys_clk), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .ext_en(ext_en), .ext_val(ext_val), .gpio_pin(gpio_pin), .rcv_clk(rcv_clk));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                     output rcmio_word_t rd);
    @(posedge sys_clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h0, wd};
    avs_read <= !w;
    avs_write <= w;
    waits = 0;
    do
    begin
      @(posedge sys_clk);
      waits++;
    end
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    rcmio_word_t junk;
    bus(1'b1, idx, d, junk);
  endtask
  task automatic rd_chk(input string what, input logic [7:0] idx, input logic [31:0] exp);
    rcmio_word_t got;
    bus(1'b0, idx, 8'h00, got);
    chk(what, exp, got);
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (21) @(posedge sys_clk);
    rst_n <= 1'b1;
  endtask
  task automatic follow(input int n, input logic hold_a);
    rcmio_chan_t h[0:2];
    int          bad_a, bad_b;
    bad_a = 0;
    bad_b = 0;
    for (int i = 0; i < n; i++)
    begin
      @(posedge sys_clk);
      if (i >= 8 && ref_a !== (hold_a ? 1'b1 : h[2][2])) bad_a++;
      if (i >= 8 && ref_b !== h[2][6]) bad_b++;
      h[2] = h[1];
      h[1] = h[0];
      h[0] = rcv_clk;
    end
    chk("ref a", 0, bad_a);
    chk("ref b", 0, bad_b);
  endtask
  task automatic count(input int n, output int a, output int t, output int e);
    logic pa, pt, pe;
    {a, t, e} = '0;
    {pa, pt, pe} = {ref_a, gen_t1, gen_e1};
    repeat (n)
    begin
      @(posedge sys_clk);
      a += int'(ref_a & !pa);
      t += int'(gen_t1 & !pt);
      e += int'(gen_e1 & !pe);
      {pa, pt, pe} = {ref_a, gen_t1, gen_e1};
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_boot();
    rcmio_word_t d;
    bus(1'b0, 8'h07, 8'h00, d);
    chk("startup wait", 1, waits > BOOT);
    chk("refsel reset", 0, d);
  endtask
  task automatic t_regs();
    rd_chk("gpio reset", 8'h06, 32'h0c);
    chk("one wait", 2, waits);
    rd_chk("refctl reset", 8'h3e, 0);
    wr(8'h07, 8'hff);
    rd_chk("refsel rw", 8'h07, 32'h77);
    avs_byteenable <= 4'he;
    wr(8'h07, 8'h00);
    avs_byteenable <= 4'hf;
    rd_chk("lane off", 8'h07, 32'h77);
    wr(8'h20, 8'h5a);
    rd_chk("unmapped", 8'h20, 0);
  endtask
  task automatic t_straps();
    logic [12:0] k;
    for (int s = 0; s < 8; s++)
    begin
      k = 13'(((s > 3) ? 2048 : 1544) * (s % 4 + 1));
      strap <= 3'(s);
      do_reset();
      rd_chk("osc rate", 8'h43, {16'h0, k, 3'(s)});
    end
  endtask
  task automatic t_loss();
    wr(8'h42, 8'h08);
    chan_loss <= 8'h28;
    repeat (4) @(posedge sys_clk);
    chk("loss pins", 8'h28, loss_pins);
    chk("irq up", 1, irq);
    rd_chk("status", 8'h40, 8'h28);
    chan_loss <= 8'h00;
    repeat (4) @(posedge sys_clk);
    chk("loss gone", 0, loss_pins);
    chk("irq sticky", 1, irq);
    wr(8'h41, 8'h08);
    @(posedge sys_clk);
    chk("irq masked", 0, irq);
    rd_chk("status left", 8'h40, 8'h20);
    wr(8'h41, 8'hff);
  endtask
  task automatic t_ref();
    int a, t, e;
    wr(8'h07, 8'h62);
    wr(8'h3e, 8'h01);
    follow(40, 1'b0);
    chan_loss <= 8'h24;
    follow(40, 1'b1);
    wr(8'h3e, 8'h02);
    count(1000, a, t, e);
    chk("mclk e1", 1, a inside {10, 11});
    chk("gen t1", 1, t inside {7, 8});
    chk("gen e1", 1, e inside {10, 11});
    wr(8'h3e, 8'h00);
    count(1000, a, t, e);
    chk("mclk t1", 1, a inside {7, 8});
    chan_loss <= 8'h00;
    @(posedge sys_clk);
    #1;
    chk("crystal out", 0, xtal);
  endtask
  task automatic t_gpio();
    ext_en <= 2'b10;
    wr(8'h06, 8'h09);
    @(posedge sys_clk);
    chk("gpio oe", 2'b01, gpio_oe);
    chk("gpio pin0", 0, gpio_pin[0]);
    rd_chk("gpio in low", 8'h06, 8'h01);
    ext_val <= 2'b10;
    repeat (3) @(posedge sys_clk);
    rd_chk("gpio in high", 8'h06, 8'h09);
    ext_en <= 2'b00;
    wr(8'h06, 8'h06);
    @(posedge sys_clk);
    chk("gpio oe swap", 2'b10, gpio_oe);
    chk("gpio pin1", 0, gpio_pin[1]);
    repeat (3) @(posedge sys_clk);
    rd_chk("gpio pull-up", 8'h06, 8'h06);
  endtask
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      test_done();
    end
  end
  initial
  begin
    do_reset();
    t_boot();
    t_regs();
    t_straps();
    t_loss();
    t_ref();
    t_gpio();
    test_done();
  end
endmodule
